//--- design/idls_pkg.sv
/*
  Shared constants for the input debounce and local switch block: register map,
  field layouts, timing counts and the switch type decode.
  Assumes a 40 MHz reference clock and a 60 Hz power system.
*/
package idls_pkg;

  // Bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // Block sizes
  localparam int NUM_INPUTS = 6;
  localparam int NUM_SWITCHES = 16;

  // Register offsets
  localparam logic [7:0] DEB_BASE = 8'h00;
  localparam logic [7:0] INPUT_STATE = 8'h08;
  localparam logic [7:0] LOCAL_BITS = 8'h09;
  localparam logic [7:0] SWITCH_CMD = 8'h0a;
  localparam logic [7:0] CFG_BASE = 8'h10;

  // Debounce setting field: hundredths of a cycle in [6:0]
  localparam int DEB_SET_W = 7;
  localparam logic [6:0] DEB_MAX_HUND = 7'h64;
  localparam int DEB_TICKS_LSB = 8;
  localparam int DEB_TICKS_W = 5;
  localparam logic [10:0] ROUND_BIAS = 11'h032;
  localparam logic [10:0] HUND_DIV = 11'h064;

  // Switch config field: label present bits
  localparam int LBL_NAME = 0;
  localparam int LBL_CLEAR = 1;
  localparam int LBL_SET = 2;
  localparam int LBL_PULSE = 3;
  localparam int CFG_TYPE_LSB = 4;

  // Switch command field: index [3:0], position [5:4]
  localparam int CMD_IDX_LSB = 0;
  localparam int CMD_POS_LSB = 4;
  localparam logic [1:0] POS_CLEAR = 2'h0;
  localparam logic [1:0] POS_SET = 2'h1;
  localparam logic [1:0] POS_PULSE = 2'h2;

  // Timing: one sixteenth of a 60 Hz cycle in ns, and in 25 ns clocks
  localparam int CLK_PERIOD_NS = 25;
  localparam int SIXTEENTH_CYCLE_NS = 1041666;
  localparam int SIXTEENTH_CLKS = SIXTEENTH_CYCLE_NS / CLK_PERIOD_NS;
  localparam logic [1:0] QUARTER_LAST = 2'h3;

  // Switch types
  typedef enum logic [2:0] {
    SW_DISABLED = 3'b000,
    SW_ON_OFF = 3'b001,
    SW_OFF_MOM = 3'b010,
    SW_ON_OFF_MOM = 3'b011,
    SW_INVALID = 3'b100
  } idls_sw_type_t;

  // Type follows from which labels are present
  function automatic idls_sw_type_t sw_type(input logic [3:0] labels);
    unique case (labels)
      4'b0000: return SW_DISABLED;
      4'b0111: return SW_ON_OFF;
      4'b1011: return SW_OFF_MOM;
      4'b1111: return SW_ON_OFF_MOM;
      default: return SW_INVALID;
    endcase
  endfunction

endpackage

//--- design/idls_sw_if.sv
/*
  Carrier between the register front end and one local switch.
  Assumes the command strobe is one clock long.
*/
interface idls_sw_if;
  logic cmd_valid;
  logic [1:0] cmd_pos;
  logic [3:0] labels;
  logic local_bit;

  modport ctrl (output cmd_valid, output cmd_pos, output labels, input local_bit);
  modport sw (input cmd_valid, input cmd_pos, input labels, output local_bit);
endinterface

//--- design/idls_debounce.sv
/*
  Symmetric pickup/dropout debounce for one isolated input.
  Assumes raw_i is synchronous, tick_i marks each sixteenth cycle and qtick_i
  every fourth tick.
*/
module idls_debounce (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic tick_i,
  input wire logic qtick_i,
  input wire logic raw_i,
  input wire logic [4:0] ticks_i,
  output logic state_o
);

  logic [4:0] cnt_reg;
  logic filt_reg;
  logic state_reg;

  // Same count for both edges; the old level seen at any tick restarts it
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      cnt_reg <= 5'h00;
      filt_reg <= 1'b0;
    end
    else if (tick_i)
    begin
      if (raw_i == filt_reg)
        cnt_reg <= 5'h00;
      else if (cnt_reg + 5'h01 >= ticks_i)
      begin
        filt_reg <= raw_i;
        cnt_reg <= 5'h00;
      end
      else
        cnt_reg <= cnt_reg + 5'h01;
    end
  end

  // Visible bit refreshed once per processing interval
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
      state_reg <= 1'b0;
    else if (qtick_i)
      state_reg <= filt_reg;
  end

  assign state_o = state_reg;

  property p_zero_pass;
    @(posedge ref_clk_i) disable iff (reset_i)
    tick_i && ticks_i == 5'h00 |=> filt_reg == $past(raw_i);
  endproperty
  a_zero_pass: assert property (p_zero_pass) else $error("zero setting did not pass input");

  property p_hold_until_time;
    @(posedge ref_clk_i) disable iff (reset_i)
    tick_i && raw_i != filt_reg && cnt_reg + 5'h01 < ticks_i |=> $stable(filt_reg);
  endproperty
  a_hold_until_time: assert property (p_hold_until_time) else $error("input changed early");

  property p_state_on_qtick;
    @(posedge ref_clk_i) disable iff (reset_i)
    !qtick_i |=> $stable(state_o);
  endproperty
  a_state_on_qtick: assert property (p_state_on_qtick) else $error("state moved off interval");

  c_input_change: cover property (@(posedge ref_clk_i) disable iff (reset_i) $rose(state_o));

endmodule

//--- design/idls_switch.sv
/*
  One local control switch driving one local bit.
  Assumes commands are one-clock strobes and qtick_i marks processing intervals.
*/
module idls_switch (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic qtick_i,
  idls_sw_if.sw bus
);

  idls_pkg::idls_sw_type_t sw_type;
  logic set_ok;
  logic clear_ok;
  logic pulse_ok;
  logic bit_reg;
  logic pend_reg;
  logic act_reg;

  // Positions usable only when their label is set and the type is legal
  always_comb
  begin
    sw_type = idls_pkg::sw_type(bus.labels);
    set_ok = sw_type == idls_pkg::SW_ON_OFF || sw_type == idls_pkg::SW_ON_OFF_MOM;
    pulse_ok = sw_type == idls_pkg::SW_OFF_MOM || sw_type == idls_pkg::SW_ON_OFF_MOM;
    clear_ok = set_ok || pulse_ok;
  end

  // Bit state, pending pulse and active pulse
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      bit_reg <= 1'b0;
      pend_reg <= 1'b0;
      act_reg <= 1'b0;
    end
    else if (!clear_ok)
    begin
      bit_reg <= 1'b0;
      pend_reg <= 1'b0;
      act_reg <= 1'b0;
    end
    else if (bus.cmd_valid && bus.cmd_pos == idls_pkg::POS_SET && set_ok)
    begin
      bit_reg <= 1'b1;
      pend_reg <= 1'b0;
      act_reg <= 1'b0;
    end
    else if (bus.cmd_valid && bus.cmd_pos == idls_pkg::POS_CLEAR)
    begin
      bit_reg <= 1'b0;
      pend_reg <= 1'b0;
      act_reg <= 1'b0;
    end
    else
    begin
      if (bus.cmd_valid && bus.cmd_pos == idls_pkg::POS_PULSE && pulse_ok)
        pend_reg <= 1'b1;
      else if (qtick_i)
        pend_reg <= 1'b0;
      if (qtick_i)
      begin
        if (pend_reg)
        begin
          bit_reg <= 1'b1;
          act_reg <= 1'b1;
        end
        else if (act_reg)
        begin
          bit_reg <= 1'b0;
          act_reg <= 1'b0;
        end
      end
    end
  end

  assign bus.local_bit = bit_reg;

  property p_disabled_zero;
    @(posedge ref_clk_i) disable iff (reset_i)
    !clear_ok |=> !bus.local_bit;
  endproperty
  a_disabled_zero: assert property (p_disabled_zero) else $error("disabled switch bit set");

  property p_set_drives_one;
    @(posedge ref_clk_i) disable iff (reset_i)
    bus.cmd_valid && bus.cmd_pos == idls_pkg::POS_SET && set_ok |=> bus.local_bit;
  endproperty
  a_set_drives_one: assert property (p_set_drives_one) else $error("set did not assert bit");

  property p_pulse_one_interval;
    @(posedge ref_clk_i) disable iff (reset_i)
    qtick_i && act_reg && !pend_reg && !bus.cmd_valid && clear_ok |=> !bus.local_bit;
  endproperty
  a_pulse_one_interval: assert property (p_pulse_one_interval) else $error("pulse too long");

  property p_unlabelled_ignored;
    @(posedge ref_clk_i) disable iff (reset_i)
    bus.cmd_valid && bus.cmd_pos == idls_pkg::POS_SET && !set_ok && clear_ok && !qtick_i
      |=> $stable(bus.local_bit);
  endproperty
  a_unlabelled_ignored: assert property (p_unlabelled_ignored) else $error("absent position acted");

  c_pulse_seen: cover property (@(posedge ref_clk_i) disable iff (reset_i)
    $rose(act_reg));

endmodule

//--- design/idls_top.sv
/*
  Isolated input debounce and sixteen local control switches with a plain
  register port: six debounce settings, the input state word, the local bit
  word, a switch command word and sixteen label presence words. Read data
  come from a flip-flop and stand for one cycle only; writes never wait.
  Assumes raw inputs are synchronous to ref_clk_i, a 40 MHz clock, a 60 Hz
  power system, and that power-loss retention of the local bits is handled
  by whatever preserves state around reset_i.
  Assumes the register master never raises both strobes in one cycle.
*/
// Overview of operation
// - One debounce setting per input serves both pickup and dropout.
// - Debounce settings from 0.00 to 1.00 cycle are accepted.
// - Entered debounce rounds to nearest sixteenth cycle; timer runs that.
// - Input state bits are refreshed once every quarter cycle.
// - Each input bit is just the debounced level, usable anywhere.
// - Sixteen identical local switches each drive one local bit.
// - A switch position exists only when its label is configured.
// - Set gives 1, clear gives 0, pulse gives 1 for one interval.
// - The name label names the switch, not any position.
// - Each switch is maintained, momentary, or maintained with momentary.
// - Maintained switch holds the last selected set or clear level.
// - Momentary switch rests at 0, pulses 1 for one quarter cycle.
// - Labels required depend on type: name, clear, then set/pulse.
// - All labels nulled disables the switch and forces bit to 0.
// - Bits keep state; a newly enabled switch starts at 0.
module idls_top #(
  parameter int SIXTEENTH_CLKS = idls_pkg::SIXTEENTH_CLKS
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [5:0] raw_input_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  output logic [5:0] isolated_input_state_o,
  output logic [15:0] local_switch_bit_o,
  output logic proc_tick_o
);

  logic [16:0] div_reg;
  logic [1:0] quarter_reg;
  logic tick;
  logic qtick;
  logic [6:0] deb_set_reg [idls_pkg::NUM_INPUTS];
  logic [4:0] deb_ticks_reg [idls_pkg::NUM_INPUTS];
  logic [3:0] labels_reg [idls_pkg::NUM_SWITCHES];
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic cmd_wr;
  logic [3:0] cmd_idx;
  logic [1:0] cmd_pos;
  logic cfg_hit;
  logic deb_hit;
  logic [3:0] cfg_idx;
  logic [2:0] deb_idx;
  logic [17:0] ivl_cnt_reg;
  logic ivl_seen_reg;

  // Nearest sixteenth, half rounds up: (h*16 + 50) / 100
  function automatic logic [4:0] round16(input logic [6:0] hund);
    logic [10:0] prod;
    prod = ({4'h0, hund} << 4) + idls_pkg::ROUND_BIAS;
    return 5'(prod / idls_pkg::HUND_DIV);
  endfunction

  // Sixteenth-cycle divider and quarter-cycle grouping
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      div_reg <= 17'h00000;
      quarter_reg <= 2'h0;
    end
    else if (tick)
    begin
      div_reg <= 17'h00000;
      quarter_reg <= quarter_reg + 2'h1;
    end
    else
      div_reg <= div_reg + 17'h00001;
  end

  assign tick = div_reg == 17'(SIXTEENTH_CLKS - 1);
  assign qtick = tick && quarter_reg == idls_pkg::QUARTER_LAST;
  assign proc_tick_o = qtick;

  // Clocks since the last processing tick, for the interval check
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ivl_cnt_reg <= 18'h00000;
      ivl_seen_reg <= 1'b0;
    end
    else if (qtick)
    begin
      ivl_cnt_reg <= 18'h00000;
      ivl_seen_reg <= 1'b1;
    end
    else
      ivl_cnt_reg <= ivl_cnt_reg + 18'h00001;
  end

  // Address decode
  always_comb
  begin
    deb_hit = reg_addr_i < 8'(idls_pkg::NUM_INPUTS);
    deb_idx = reg_addr_i[2:0];
    cfg_hit = reg_addr_i[7:4] == idls_pkg::CFG_BASE[7:4];
    cfg_idx = reg_addr_i[3:0];
    cmd_wr = reg_wr_i && reg_addr_i == idls_pkg::SWITCH_CMD;
    cmd_idx = reg_wdata_i[idls_pkg::CMD_IDX_LSB +: 4];
    cmd_pos = reg_wdata_i[idls_pkg::CMD_POS_LSB +: 2];
  end

  // Debounce settings; values above one cycle are refused
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      for (int i = 0; i < idls_pkg::NUM_INPUTS; i++)
      begin
        deb_set_reg[i] <= 7'h00;
        deb_ticks_reg[i] <= 5'h00;
      end
    end
    else if (reg_wr_i && deb_hit && reg_wdata_i[6:0] <= idls_pkg::DEB_MAX_HUND
             && reg_wdata_i[15:7] == 9'h000)
    begin
      deb_set_reg[deb_idx] <= reg_wdata_i[6:0];
      deb_ticks_reg[deb_idx] <= round16(reg_wdata_i[6:0]);
    end
  end

  // Switch label presence registers
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      for (int i = 0; i < idls_pkg::NUM_SWITCHES; i++)
        labels_reg[i] <= 4'h0;
    end
    else if (reg_wr_i && cfg_hit)
      labels_reg[cfg_idx] <= reg_wdata_i[3:0];
  end

  // Read mux; unmapped reads return zero
  always_comb
  begin
    rdata_next = 16'h0000;
    if (deb_hit)
    begin
      rdata_next[idls_pkg::DEB_SET_W-1:0] = deb_set_reg[deb_idx];
      rdata_next[idls_pkg::DEB_TICKS_LSB +: idls_pkg::DEB_TICKS_W] = deb_ticks_reg[deb_idx];
    end
    else if (reg_addr_i == idls_pkg::INPUT_STATE)
      rdata_next[5:0] = isolated_input_state_o;
    else if (reg_addr_i == idls_pkg::LOCAL_BITS)
      rdata_next = local_switch_bit_o;
    else if (cfg_hit)
    begin
      rdata_next[3:0] = labels_reg[cfg_idx];
      rdata_next[idls_pkg::CFG_TYPE_LSB +: 3] = idls_pkg::sw_type(labels_reg[cfg_idx]);
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
      rdata_reg <= 16'h0000;
    else if (reg_rd_i)
      rdata_reg <= rdata_next;
    else
      rdata_reg <= 16'h0000;
  end

  assign reg_rdata_o = rdata_reg;

  // Debouncers, one per isolated input
  for (genvar g = 0; g < idls_pkg::NUM_INPUTS; g++)
  begin : g_in
    idls_debounce u_deb (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .tick_i(tick),
      .qtick_i(qtick),
      .raw_i(raw_input_i[g]),
      .ticks_i(deb_ticks_reg[g]),
      .state_o(isolated_input_state_o[g])
    );
  end

  // Local switches, identical logic per bit
  for (genvar g = 0; g < idls_pkg::NUM_SWITCHES; g++)
  begin : g_sw
    idls_sw_if sw_if ();
    assign sw_if.cmd_valid = cmd_wr && cmd_idx == 4'(g);
    assign sw_if.cmd_pos = cmd_pos;
    assign sw_if.labels = labels_reg[g];
    assign local_switch_bit_o[g] = sw_if.local_bit;
    idls_switch u_sw (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .qtick_i(qtick),
      .bus(sw_if.sw)
    );
  end

  property p_qtick_every_fourth;
    @(posedge ref_clk_i) disable iff (reset_i)
    qtick && ivl_seen_reg |-> tick && ivl_cnt_reg == 18'(4 * SIXTEENTH_CLKS - 1);
  endproperty
  a_qtick_every_fourth: assert property (p_qtick_every_fourth) else $error("bad interval tick");

  property p_round_nearest;
    @(posedge ref_clk_i) disable iff (reset_i)
    reg_wr_i && deb_hit && reg_wdata_i == 16'h0050
      |=> deb_ticks_reg[$past(deb_idx)] == 5'h0d;
  endproperty
  a_round_nearest: assert property (p_round_nearest) else $error("0.80 did not round to 13");

  property p_full_cycle;
    @(posedge ref_clk_i) disable iff (reset_i)
    reg_wr_i && deb_hit && reg_wdata_i == 16'h0064
      |=> deb_ticks_reg[$past(deb_idx)] == 5'h10;
  endproperty
  a_full_cycle: assert property (p_full_cycle) else $error("1.00 did not give 16");

  property p_out_of_range;
    @(posedge ref_clk_i) disable iff (reset_i)
    reg_wr_i && deb_hit && reg_wdata_i > 16'h0064
      |=> deb_set_reg[$past(deb_idx)] == $past(deb_set_reg[deb_idx]);
  endproperty
  a_out_of_range: assert property (p_out_of_range) else $error("over-range setting taken");

  property p_read_one_cycle;
    @(posedge ref_clk_i) disable iff (reset_i)
    !reg_rd_i |=> reg_rdata_o == 16'h0000;
  endproperty
  a_read_one_cycle: assert property (p_read_one_cycle) else $error("read data outside slot");

  property p_local_read;
    @(posedge ref_clk_i) disable iff (reset_i)
    reg_rd_i && reg_addr_i == 8'h09 |=> reg_rdata_o == $past(local_switch_bit_o);
  endproperty
  a_local_read: assert property (p_local_read) else $error("local bit readback wrong");

  // Register file contents and readback
  property p_input_read;
    @(posedge ref_clk_i) disable iff (reset_i)
    reg_rd_i && reg_addr_i == idls_pkg::INPUT_STATE
      |=> reg_rdata_o == {10'h000, $past(isolated_input_state_o)};
  endproperty
  a_input_read: assert property (p_input_read) else $error("input state readback wrong");

  property p_label_write;
    @(posedge ref_clk_i) disable iff (reset_i)
    reg_wr_i && cfg_hit |=> labels_reg[$past(cfg_idx)] == $past(reg_wdata_i[3:0]);
  endproperty
  a_label_write: assert property (p_label_write) else $error("label write lost");

  property p_deb_taken;
    @(posedge ref_clk_i) disable iff (reset_i)
    reg_wr_i && deb_hit && reg_wdata_i <= 16'h0064
      |=> deb_set_reg[$past(deb_idx)] == $past(reg_wdata_i[6:0]);
  endproperty
  a_deb_taken: assert property (p_deb_taken) else $error("in-range setting refused");

  property p_ticks_bounded;
    @(posedge ref_clk_i) disable iff (reset_i)
    reg_wr_i && deb_hit |=> deb_ticks_reg[$past(deb_idx)] <= 5'h10;
  endproperty
  a_ticks_bounded: assert property (p_ticks_bounded) else $error("rounded time above cycle");

  property p_type_full_read;
    @(posedge ref_clk_i) disable iff (reset_i)
    reg_rd_i && cfg_hit && labels_reg[cfg_idx] == 4'hf |=> reg_rdata_o[6:4] == 3'h3;
  endproperty
  a_type_full_read: assert property (p_type_full_read) else $error("three-way type wrong");

  property p_type_null_read;
    @(posedge ref_clk_i) disable iff (reset_i)
    reg_rd_i && cfg_hit && labels_reg[cfg_idx] == 4'h0 |=> reg_rdata_o[6:4] == 3'h0;
  endproperty
  a_type_null_read: assert property (p_type_null_read) else $error("nulled type wrong");

  c_cmd_write: cover property (@(posedge ref_clk_i) disable iff (reset_i) cmd_wr);
  c_qtick: cover property (@(posedge ref_clk_i) disable iff (reset_i) qtick);
  c_deb_refused: cover property (@(posedge ref_clk_i) disable iff (reset_i)
    reg_wr_i && deb_hit && reg_wdata_i > 16'h0064);

endmodule

//--- bench/idls_field_contacts.sv
/*
  Field contact model for the six isolated inputs: raw levels follow a
  target, with optional chatter on changed bits after each change.
  Assumes the bench changes target_i by non-blocking assignment at an edge.
*/
module idls_field_contacts (
  input wire logic ref_clk_i,
  input wire logic [5:0] target_i,
  input wire logic bounce_en_i,
  output logic [5:0] raw_o
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [5:0] last_reg = 6'h00;
  logic [5:0] flip_reg = 6'h00;
  int chatter_cnt = 0;
  int seed = 47104;

  initial raw_o = 6'h00;

  // Chatter lasts under two ticks, shorter than any debounce of two ticks or more
  always @(posedge ref_clk_i)
  begin
    if (bounce_en_i && target_i != last_reg)
    begin
      chatter_cnt <= 5;
      flip_reg <= target_i ^ last_reg;
    end
    else if (chatter_cnt > 0)
      chatter_cnt <= chatter_cnt - 1;
    last_reg <= target_i;
    raw_o <= (chatter_cnt > 0) ? target_i ^ (6'($random(seed)) & flip_reg) : target_i;
  end
endmodule

//--- bench/tb_idls_top.sv
/*
  Self-checking bench for the debounce and local switch block.
  Assumes the short divider parameter: one processing interval is 16 clocks.
*/
module tb_idls_top;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int SXT = 4;
  localparam int IVL = SXT * 4;

  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [5:0] tgt = 6'h00;
  logic bounce = 1'b0;
  logic [5:0] raw;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [15:0] rdata;
  logic [5:0] state;
  logic [15:0] lbits;
  logic ptick;
  logic rd_seen = 1'b0;
  logic tick_prev = 1'b0;
  logic [5:0] state_prev = 6'h00;
  logic [5:0] seen_hi = 6'h00;
  logic [5:0] seen_lo = 6'h3f;
  logic [15:0] exp_q[$];
  logic [15:0] mask;
  int fails = 0;
  int checked = 0;
  int seed = 47104;
  int w;

  idls_field_contacts u_field (.ref_clk_i(ref_clk_i), .target_i(tgt), .bounce_en_i(bounce),
    .raw_o(raw));

  idls_top #(.SIXTEENTH_CLKS(SXT)) u_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .raw_input_i(raw), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr_s),
    .reg_rd_i(rd_s), .reg_rdata_o(rdata), .isolated_input_state_o(state),
    .local_switch_bit_o(lbits), .proc_tick_o(ptick));

  // Clock
  initial
  begin
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge ref_clk_i);
    wr_s <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    exp_q.push_back(exp);
    @(posedge ref_clk_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge ref_clk_i);
    rd_s <= 1'b0;
  endtask

  task automatic cmd(input logic [3:0] idx, input logic [1:0] pos);
    wr(8'h0a, {10'h000, pos, idx});
  endtask

  // Cycles a local bit stays high, bounded waits, looked at 1 ns after edges
  task automatic pulse_len(input int n, output int len);
    int i;
    len = 0;
    for (i = 0; i < 200 && lbits[n] !== 1'b1; i++)
    begin
      @(posedge ref_clk_i);
      #1;
    end
    if (i == 200)
      fails++;
    for (i = 0; i < 200 && lbits[n] === 1'b1; i++)
    begin
      @(posedge ref_clk_i);
      #1;
      len++;
    end
  endtask

  // Type expected from the label set
  function automatic logic [2:0] exp_type(input logic [3:0] lab);
    case (lab)
      4'h0: return 3'h0;
      4'h7: return 3'h1;
      4'hb: return 3'h2;
      4'hf: return 3'h3;
      default: return 3'h4;
    endcase
  endfunction

  function automatic logic [15:0] exp_deb(input int h);
    return 16'((((h * 16 + 50) / 100) << 8) | h);
  endfunction

  // Read data taken in the cycle after the strobe
  always @(posedge ref_clk_i)
  begin
    if (rd_seen)
      check(rdata, exp_q.pop_front());
    rd_seen <= rd_s;
  end

  // State bits move only after a processing tick; extremes recorded
  always @(posedge ref_clk_i)
  begin
    if (!reset_i && state !== state_prev)
      check({15'h0000, tick_prev}, 16'h0001);
    tick_prev <= ptick;
    state_prev <= state;
    seen_hi = seen_hi | state;
    seen_lo = seen_lo & state;
  end

  // Watchdog
  initial
  begin
    cyc(100000);
    fails++;
    end_sim();
  end

  // Main sequence
  initial
  begin
    int h;
    cyc(2);
    reset_i <= 1'b0;
    rd(8'h08, 16'h0000);
    rd(8'h09, 16'h0000);
    rd(8'h30, 16'h0000);
    for (int k = 0; k < 6; k++)
    begin
      h = (k == 5) ? 100 : (k == 4) ? 80 : (k == 0) ? 0 : $unsigned($random(seed)) % 101;
      wr(8'(k), 16'(h));
      rd(8'(k), exp_deb(h));
    end
    for (int k = 0; k < 6; k++)
      wr(8'(k), (k == 2) ? 16'h0000 : 16'h0019);
    wr(8'h00, 16'h0065);
    rd(8'h00, exp_deb(25));
    cyc(40);
    // Pulse of three ticks is filtered, four ticks passes
    seen_hi = 6'h00;
    tgt <= 6'h01;
    cyc(12);
    tgt <= 6'h00;
    cyc(48);
    check({15'h0000, seen_hi[0]}, 16'h0000);
    seen_hi = 6'h00;
    tgt <= 6'h01;
    cyc(16);
    tgt <= 6'h00;
    cyc(48);
    check({15'h0000, seen_hi[0]}, 16'h0001);
    // Same delay on dropout
    tgt <= 6'h01;
    cyc(60);
    seen_lo = 6'h3f;
    tgt <= 6'h00;
    cyc(12);
    tgt <= 6'h01;
    cyc(48);
    check({15'h0000, seen_lo[0]}, 16'h0001);
    tgt <= 6'h00;
    cyc(16);
    tgt <= 6'h01;
    cyc(48);
    check({15'h0000, seen_lo[0]}, 16'h0000);
    // Random patterns with chatter
    bounce <= 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      tgt <= 6'($random(seed));
      cyc(80);
      rd(8'h08, {10'h000, tgt});
    end
    for (int k = 0; k < 16; k++)
    begin
      wr(8'h10, 16'(k));
      rd(8'h10, {9'h000, exp_type(4'(k)), 4'(k)});
    end
    // Maintained switch
    wr(8'h13, 16'h0007);
    cmd(4'h3, 2'h1);
    rd(8'h09, 16'h0008);
    cmd(4'h3, 2'h2);
    cyc(40);
    rd(8'h09, 16'h0008);
    cmd(4'h3, 2'h3);
    cmd(4'h3, 2'h0);
    rd(8'h09, 16'h0000);
    cmd(4'h3, 2'h1);
    wr(8'h13, 16'h0000);
    rd(8'h09, 16'h0000);
    cmd(4'h3, 2'h1);
    rd(8'h09, 16'h0000);
    wr(8'h13, 16'h0007);
    rd(8'h09, 16'h0000);
    cmd(4'h3, 2'h1);
    wr(8'h13, 16'h0003);
    rd(8'h09, 16'h0000);
    // Momentary switches
    wr(8'h15, 16'h000b);
    cmd(4'h5, 2'h1);
    rd(8'h09, 16'h0000);
    cmd(4'h5, 2'h2);
    pulse_len(5, w);
    check(16'(w), 16'(IVL));
    wr(8'h17, 16'h000f);
    cmd(4'h7, 2'h2);
    pulse_len(7, w);
    check(16'(w), 16'(IVL));
    cmd(4'h7, 2'h1);
    rd(8'h09, 16'h0080);
    cmd(4'h7, 2'h0);
    rd(8'h09, 16'h0000);
    // All sixteen switches independent
    mask = 16'($random(seed));
    for (int k = 0; k < 16; k++)
      wr(8'h10 + 8'(k), 16'h0007);
    for (int k = 0; k < 16; k++)
      cmd(4'(k), {1'b0, mask[k]});
    rd(8'h09, mask);
    wr(8'h09, 16'hffff);
    rd(8'h09, mask);
    cyc(4);
    check(lbits, mask);
    end_sim();
  end
endmodule
